// file: hw/dbgev_cnt_if.sv
// carrier between the main block and one breakpoint counter
`timescale 1ns/10ps
interface dbgev_cnt_if;
  logic        load;
  logic [31:0] load_word;
  logic        ibus_evt;
  logic        lbus_evt;
  logic [15:0] count;
  logic [1:0]  sel;
  logic        expire;
  modport ctl (output load, load_word, ibus_evt, lbus_evt, input count, sel, expire);
  modport cnt (input load, load_word, ibus_evt, lbus_evt, output count, sel, expire);
endinterface

// file: hw/dbgev_counter.sv
// one breakpoint counter with preset and source select
`timescale 1ns/10ps
module dbgev_counter
  import dbgev_pkg::*;
(
  input  wire logic clock,
  input  wire logic arst_n,
  dbgev_cnt_if.cnt  bus
);
  logic evt;

  always_comb begin
    evt = 1'b0;
    case (bus.sel)
      SRC_IBUS: evt = bus.ibus_evt;
      SRC_LBUS: evt = bus.lbus_evt;
      default:  evt = 1'b0; // reserved code counts nothing
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus.sel <= SRC_OFF; // see RULE8
    end else if (bus.load) begin
      bus.sel <= bus.load_word[CNT_SRC_LO +: 2]; // see RULE6
    end
  end

  // preset is don't-care after reset; zero keeps it defined
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus.count <= CNT_PRESET_RESET;
    end else if (bus.load) begin
      bus.count <= bus.load_word[CNT_PRESET_LO +: 16];
    end else if (evt && bus.count != 16'h0000) begin
      bus.count <= bus.count - 16'h0001; // see RULE21
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus.expire <= 1'b0;
    end else begin
      bus.expire <= !bus.load && evt && bus.count == 16'h0001; // see RULE21
    end
  end

  AST_CNT_DECREMENT: assert property (@(posedge clock) disable iff (!arst_n) // see RULE21
    (!bus.load && evt && bus.count != 16'h0000) |=> bus.count == $past(bus.count) - 16'h0001)
    else $error("counter did not step down on its event");
  AST_CNT_INACTIVE: assert property (@(posedge clock) disable iff (!arst_n) // see RULE6
    (!bus.load && bus.sel == SRC_OFF) |=> $stable(bus.count) && !bus.expire)
    else $error("inactive counter moved");
endmodule // dbgev_counter

// file: hw/dbgev_pkg.sv
// constants, field layout and reset values of the debug event entry logic
// What this block does
// RULE1: non-mask bit forces breakpoint recognition regardless
// RULE2: bits 28,29 read-only devport trap enables
// RULE3: bits 30,31 software trap enables, writable
// RULE4: reset clears whole second watchpoint control
// RULE5: watchpoint needs all three selected conditions
// RULE6: counter A: preset, source select, encoding
// RULE7: counter B same, second watchpoint sources
// RULE8: reset clears counter control, preset undefined
// RULE9: hardware sets causes; read clears when allowed
// RULE10: writes to cause register are ignored
// RULE11: entry needs debug enabled and enable bit
// RULE12: reset clears every cause bit
// RULE13: checkstop and machine check cause bits
// RULE14: exception cause bits set on assertion
// RULE15: trace cause on single-step or branch trace
// RULE16: breakpoint and external breakpoint cause bits
// RULE17: devport cause on request or reset entry
// RULE18: enable bit per cause blocks or permits
// RULE19: reset enables checkstop, trace, breakpoints, devport
// RULE20: load-address select E, F, both, either
// RULE21: counters decrement per event, expire raises breakpoint
package dbgev_pkg;
  // field bit n sits at vector index 31-n (bit 0 is the msb)
  localparam logic [9:0]  SPR_DEBUG_CAUSE   = 10'h094;
  localparam logic [9:0]  SPR_ENTRY_ENABLE  = 10'h095;
  localparam logic [9:0]  SPR_COUNTER_A     = 10'h096;
  localparam logic [9:0]  SPR_COUNTER_B     = 10'h097;
  localparam logic [9:0]  SPR_LS_WATCH_CTL2 = 10'h09D;

  localparam int CB_CHECKSTOP    = 31 - 2;
  localparam int CB_MACHINE_CHK  = 31 - 3;
  localparam int CB_DATA_STOR    = 31 - 4;
  localparam int CB_INSTR_STOR   = 31 - 5;
  localparam int CB_EXT_INT      = 31 - 6;
  localparam int CB_ALIGN        = 31 - 7;
  localparam int CB_PROGRAM      = 31 - 8;
  localparam int CB_FP_UNAVAIL   = 31 - 9;
  localparam int CB_DECREMENTER  = 31 - 10;
  localparam int CB_SYSTEM_CALL  = 31 - 13;
  localparam int CB_TRACE        = 31 - 14;
  localparam int CB_FP_ASSIST    = 31 - 15;
  localparam int CB_SW_EMUL      = 31 - 17;
  localparam int CB_LS_BRK       = 31 - 28;
  localparam int CB_INSTR_BRK    = 31 - 29;
  localparam int CB_EXT_BRK      = 31 - 30;
  localparam int CB_DEVPORT      = 31 - 31;

  localparam logic [31:0] CAUSE_MASK = 32'h3FE7_400F;
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENTRY_RESET = (32'h1 << CB_CHECKSTOP) | (32'h1 << CB_TRACE) |
                                        (32'h1 << CB_LS_BRK) | (32'h1 << CB_INSTR_BRK) |
                                        (32'h1 << CB_EXT_BRK) | (32'h1 << CB_DEVPORT);

  // per-watchpoint fields, second watchpoint sits LW_STRIDE lower
  localparam int LW_STRIDE  = 10;
  localparam int LW_EN      = 31;
  localparam int LW_IA_HI   = 30;
  localparam int LW_IADC    = 28;
  localparam int LW_LA_HI   = 27;
  localparam int LW_LADC    = 25;
  localparam int LW_LD_HI   = 24;
  localparam int LW_LDDC    = 22;
  localparam int LW_NOMASK  = 31 - 20;
  localparam int LW_DP_TRAP = 31 - 28;
  localparam int LW_SW_TRAP = 31 - 30;
  localparam logic [31:0] LSWC2_WR_MASK = 32'hFFFF_F803;
  localparam logic [31:0] LSWC2_RESET   = 32'h0000_0000;

  localparam int CNT_PRESET_LO = 16;
  localparam int CNT_SRC_LO    = 0;
  localparam logic [1:0]  SRC_OFF  = 2'h0;
  localparam logic [1:0]  SRC_IBUS = 2'h1;
  localparam logic [1:0]  SRC_LBUS = 2'h2;
  localparam logic [15:0] CNT_PRESET_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// file: hw/dbgev_top.sv
// debug cause, entry enable, breakpoint counters and watchpoint control two
`timescale 1ns/10ps
module dbgev_top
  import dbgev_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [9:0]  spr_addr,
  input  wire logic        spr_wr,
  input  wire logic        spr_rd,
  input  wire logic [31:0] spr_wdata,
  output logic      [31:0] spr_rdata,
  input  wire logic        debug_enabled,
  input  wire logic        in_debug,
  input  wire logic        recoverable_state_flag,
  input  wire logic [3:0]  ibus_watch,
  input  wire logic        ibus_brk_raw,
  input  wire logic        cmp_match_e,
  input  wire logic        cmp_match_f,
  input  wire logic        cmp_match_g,
  input  wire logic        cmp_match_h,
  input  wire logic        devport_trap_load,
  input  wire logic [1:0]  devport_trap_cfg,
  input  wire logic        evt_checkstop,
  input  wire logic        evt_machine_check,
  input  wire logic        evt_data_storage,
  input  wire logic        evt_instr_storage,
  input  wire logic        evt_ext_interrupt,
  input  wire logic        evt_alignment,
  input  wire logic        evt_program,
  input  wire logic        evt_fp_unavailable,
  input  wire logic        evt_decrementer,
  input  wire logic        evt_system_call,
  input  wire logic        single_step,
  input  wire logic        branch_trace,
  input  wire logic        evt_fp_assist,
  input  wire logic        evt_sw_emulation,
  input  wire logic        ext_brk_module,
  input  wire logic        ext_brk_devport,
  input  wire logic        devport_nmi,
  input  wire logic        debug_from_reset,
  output logic             debug_entry_req,
  output logic [1:0]       ls_watch,
  output logic             ls_breakpoint,
  output logic             instr_breakpoint
);
  logic [31:0] debug_cause;
  logic [31:0] debug_entry_enable;
  logic [31:0] loadstore_watch_control_two;
  logic [31:0] set_vec;
  logic [31:0] next_rdata;
  logic [1:0]  ls_watch_now;
  logic [1:0]  ls_hit;
  logic        ibus_hit;
  logic        brk_recognised;
  logic        cause_ls_breakpoint_set;
  logic        cause_instr_breakpoint_set;
  logic        cause_clear;
  logic        breakpoint_mask_override;
  logic [1:0]  devport_trap_ls;
  logic [1:0]  sw_trap_ls;

  dbgev_cnt_if cnt_a ();
  dbgev_cnt_if cnt_b ();

  assign breakpoint_mask_override = loadstore_watch_control_two[LW_NOMASK];
  assign devport_trap_ls = {loadstore_watch_control_two[LW_DP_TRAP - 1],
                            loadstore_watch_control_two[LW_DP_TRAP]};
  assign sw_trap_ls      = {loadstore_watch_control_two[LW_SW_TRAP - 1],
                            loadstore_watch_control_two[LW_SW_TRAP]};

  // load/store watchpoints: each care bit turns its condition on
  for (genvar k = 0; k < 2; k++) begin : g_watch
    localparam int B = k * LW_STRIDE;
    logic [1:0] ia_sel;
    logic [1:0] la_sel;
    logic [1:0] ld_sel;
    logic       ia_hit;
    logic       la_hit;
    logic       ld_hit;
    assign ia_sel = loadstore_watch_control_two[LW_IA_HI - B -: 2];
    assign la_sel = loadstore_watch_control_two[LW_LA_HI - B -: 2];
    assign ld_sel = loadstore_watch_control_two[LW_LD_HI - B -: 2];
    assign ia_hit = ibus_watch[ia_sel];
    always_comb begin
      case (la_sel)
        2'h0:    la_hit = cmp_match_e; // see RULE20
        2'h1:    la_hit = cmp_match_f;
        2'h2:    la_hit = cmp_match_e & cmp_match_f;
        default: la_hit = cmp_match_e | cmp_match_f;
      endcase
    end
    always_comb begin
      case (ld_sel)
        2'h0:    ld_hit = cmp_match_g;
        2'h1:    ld_hit = cmp_match_h;
        2'h2:    ld_hit = cmp_match_g & cmp_match_h;
        default: ld_hit = cmp_match_g | cmp_match_h;
      endcase
    end
    assign ls_watch_now[k] = loadstore_watch_control_two[LW_EN - B] &
                             (ia_hit | ~loadstore_watch_control_two[LW_IADC - B]) &
                             (la_hit | ~loadstore_watch_control_two[LW_LADC - B]) &
                             (ld_hit | ~loadstore_watch_control_two[LW_LDDC - B]); // see RULE5

    AST_WATCH_ALL_THREE: assert property (@(posedge clock) disable iff (!arst_n) // see RULE5
      ls_watch[k] |-> $past(loadstore_watch_control_two[LW_EN - B]) &&
        ($past(ia_hit) || !$past(loadstore_watch_control_two[LW_IADC - B])) &&
        ($past(la_hit) || !$past(loadstore_watch_control_two[LW_LADC - B])) &&
        ($past(ld_hit) || !$past(loadstore_watch_control_two[LW_LDDC - B])))
      else $error("load/store watchpoint fired without all conditions");
  end

  // counter A follows the first watchpoints, counter B the second
  assign cnt_a.load      = spr_wr && spr_addr == SPR_COUNTER_A; // see RULE6
  assign cnt_a.load_word = spr_wdata;
  assign cnt_a.ibus_evt  = ibus_watch[0];
  assign cnt_a.lbus_evt  = ls_watch_now[0];
  assign cnt_b.load      = spr_wr && spr_addr == SPR_COUNTER_B; // see RULE7
  assign cnt_b.load_word = spr_wdata;
  assign cnt_b.ibus_evt  = ibus_watch[1];
  assign cnt_b.lbus_evt  = ls_watch_now[1];

  dbgev_counter u_cnt_a (
    .clock  (clock),
    .arst_n (arst_n),
    .bus    (cnt_a.cnt)
  );
  dbgev_counter u_cnt_b (
    .clock  (clock),
    .arst_n (arst_n),
    .bus    (cnt_b.cnt)
  );

  // a counted watchpoint traps only on expiry, an uncounted one at once
  assign ls_hit[0] = (ls_watch_now[0] & (sw_trap_ls[0] | devport_trap_ls[0]) &
                      cnt_a.sel != SRC_LBUS) | (cnt_a.expire & cnt_a.sel == SRC_LBUS);
  assign ls_hit[1] = (ls_watch_now[1] & (sw_trap_ls[1] | devport_trap_ls[1]) &
                      cnt_b.sel != SRC_LBUS) | (cnt_b.expire & cnt_b.sel == SRC_LBUS);
  assign ibus_hit  = ibus_brk_raw | (cnt_a.expire & cnt_a.sel == SRC_IBUS) |
                     (cnt_b.expire & cnt_b.sel == SRC_IBUS); // see RULE21
  assign brk_recognised = breakpoint_mask_override | recoverable_state_flag; // see RULE1
  assign cause_ls_breakpoint_set = (|ls_hit) & brk_recognised;
  assign cause_instr_breakpoint_set = ibus_hit & brk_recognised;

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[CB_CHECKSTOP]   = evt_checkstop; // see RULE13
    set_vec[CB_MACHINE_CHK] = evt_machine_check;
    set_vec[CB_DATA_STOR]   = evt_data_storage;
    set_vec[CB_INSTR_STOR]  = evt_instr_storage;
    set_vec[CB_EXT_INT]     = evt_ext_interrupt; // see RULE14
    set_vec[CB_ALIGN]       = evt_alignment;
    set_vec[CB_PROGRAM]     = evt_program;
    set_vec[CB_FP_UNAVAIL]  = evt_fp_unavailable;
    set_vec[CB_DECREMENTER] = evt_decrementer;
    set_vec[CB_SYSTEM_CALL] = evt_system_call;
    set_vec[CB_TRACE]       = single_step | branch_trace; // see RULE15
    set_vec[CB_FP_ASSIST]   = evt_fp_assist;
    set_vec[CB_SW_EMUL]     = evt_sw_emulation;
    set_vec[CB_LS_BRK]      = cause_ls_breakpoint_set; // see RULE16
    set_vec[CB_INSTR_BRK]   = cause_instr_breakpoint_set;
    set_vec[CB_EXT_BRK]     = ext_brk_module | ext_brk_devport;
    set_vec[CB_DEVPORT]     = devport_nmi | debug_from_reset; // see RULE17
  end

  assign cause_clear = spr_rd && spr_addr == SPR_DEBUG_CAUSE && (!debug_enabled || in_debug);

  // writes never reach the cause bits; a same-cycle set survives the read clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      debug_cause <= CAUSE_RESET; // see RULE12
    end else if (cause_clear) begin
      debug_cause <= set_vec; // see RULE9
    end else begin
      debug_cause <= debug_cause | set_vec; // see RULE10
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      debug_entry_enable <= ENTRY_RESET; // see RULE19
    end else if (spr_wr && spr_addr == SPR_ENTRY_ENABLE) begin
      debug_entry_enable <= spr_wdata & CAUSE_MASK; // see RULE18
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      debug_entry_req <= 1'b0;
    end else begin
      debug_entry_req <= debug_enabled && (set_vec & debug_entry_enable) != 32'h0; // see RULE11
    end
  end

  // devport trap bits only move from the development port side
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      loadstore_watch_control_two <= LSWC2_RESET; // see RULE4
    end else begin
      if (spr_wr && spr_addr == SPR_LS_WATCH_CTL2) begin
        loadstore_watch_control_two <= (spr_wdata & LSWC2_WR_MASK) |
          (loadstore_watch_control_two & ~LSWC2_WR_MASK & ~(32'h3 << (LW_DP_TRAP - 1))) |
          (loadstore_watch_control_two & (32'h3 << (LW_DP_TRAP - 1))); // see RULE3
      end
      if (devport_trap_load) begin
        loadstore_watch_control_two[LW_DP_TRAP]     <= devport_trap_cfg[0]; // see RULE2
        loadstore_watch_control_two[LW_DP_TRAP - 1] <= devport_trap_cfg[1];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ls_watch         <= 2'h0;
      ls_breakpoint    <= 1'b0;
      instr_breakpoint <= 1'b0;
    end else begin
      ls_watch         <= ls_watch_now;
      ls_breakpoint    <= cause_ls_breakpoint_set;
      instr_breakpoint <= cause_instr_breakpoint_set;
    end
  end

  always_comb begin
    case (spr_addr)
      SPR_DEBUG_CAUSE:   next_rdata = debug_cause;
      SPR_ENTRY_ENABLE:  next_rdata = debug_entry_enable;
      SPR_COUNTER_A:     next_rdata = {cnt_a.count, 14'h0000, cnt_a.sel};
      SPR_COUNTER_B:     next_rdata = {cnt_b.count, 14'h0000, cnt_b.sel};
      SPR_LS_WATCH_CTL2: next_rdata = loadstore_watch_control_two;
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      spr_rdata <= RDATA_RESET;
    end else if (spr_rd) begin
      spr_rdata <= next_rdata;
    end
  end

  AST_CAUSE_STICKY: assert property (@(posedge clock) disable iff (!arst_n) // see RULE9
    !cause_clear |=> (debug_cause & $past(debug_cause)) == $past(debug_cause))
    else $error("cause bit dropped without a clearing read");
  AST_CAUSE_READ_CLEAR: assert property (@(posedge clock) disable iff (!arst_n) // see RULE9
    (cause_clear && set_vec == 32'h0) |=> debug_cause == 32'h0 && spr_rdata == $past(debug_cause))
    else $error("cause register not cleared by read");
  AST_CAUSE_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!arst_n) // see RULE10
    (spr_wr && !spr_rd && spr_addr == SPR_DEBUG_CAUSE && set_vec == 32'h0) |=> $stable(debug_cause))
    else $error("write changed the cause register");
  AST_ENTRY_CAUSE: assert property (@(posedge clock) disable iff (!arst_n) // see RULE11
    debug_entry_req |-> $past(debug_enabled) &&
      (($past(set_vec) & $past(debug_entry_enable)) != 32'h0))
    else $error("debug entry without enabled cause");
  AST_ENTRY_BLOCKED: assert property (@(posedge clock) disable iff (!arst_n) // see RULE18
    (set_vec != 32'h0 && (set_vec & debug_entry_enable) == 32'h0) |=> !debug_entry_req)
    else $error("masked cause requested debug entry");
  AST_BRK_MASKED: assert property (@(posedge clock) disable iff (!arst_n) // see RULE1
    (!breakpoint_mask_override && !recoverable_state_flag) |=> !ls_breakpoint && !instr_breakpoint)
    else $error("breakpoint recognised while masked");
  AST_DEVPORT_READ_ONLY: assert property (@(posedge clock) disable iff (!arst_n) // see RULE2
    !devport_trap_load |=> devport_trap_ls == $past(devport_trap_ls))
    else $error("software changed a devport trap enable");
  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!arst_n) // see RULE4
    spr_wr && spr_addr == SPR_LS_WATCH_CTL2 |=> loadstore_watch_control_two[10:4] == 7'h00)
    else $error("reserved control bits became set");
  AST_CAUSE_SETS: assert property (@(posedge clock) disable iff (!arst_n) // see RULE14
    set_vec != 32'h0 |=> (debug_cause & $past(set_vec)) == $past(set_vec))
    else $error("cause bit not set by its event");
  AST_LS_BRK_CAUSE: assert property (@(posedge clock) disable iff (!arst_n) // see RULE16
    ls_breakpoint |-> debug_cause[CB_LS_BRK])
    else $error("load/store breakpoint without its cause bit");
  AST_INSTR_BRK_CAUSE: assert property (@(posedge clock) disable iff (!arst_n) // see RULE16
    instr_breakpoint |-> debug_cause[CB_INSTR_BRK])
    else $error("instruction breakpoint without its cause bit");
endmodule // dbgev_top

// file: test/dbgev_core_model.sv
// stand-in for the core exception logic and development port event sources
`timescale 1ns/10ps
module dbgev_core_model (
  input  wire logic        fire,
  input  wire logic [4:0]  fire_sel,
  output logic      [18:0] evt
);
  // one source per request, held for exactly the cycle the bench asks for
  always_comb begin
    evt = '0;
    if (fire) begin
      evt[fire_sel] = 1'b1;
    end
  end
endmodule // dbgev_core_model

// file: test/debug_event_entry_logic_tb_top.sv
// self-checking bench for the debug event entry logic
`timescale 1ns/10ps
module debug_event_entry_logic_tb_top
  import dbgev_pkg::*;
;
  localparam logic [31:0] EXP_EN = 32'h2002_000F;
  localparam logic [31:0] CAUSES = 32'h3FE7_400F;
  localparam int SRC_BIT [19] = '{29, 28, 27, 26, 25, 24, 23, 22, 21, 18, 17, 17, 16, 14,
                                  1, 1, 0, 0, 2};
  logic        clock;
  logic        arst_n;
  logic [9:0]  spr_addr;
  logic        spr_wr;
  logic        spr_rd;
  logic [31:0] spr_wdata;
  logic [31:0] spr_rdata;
  logic [31:0] rd;
  logic [31:0] en;
  logic        debug_enabled;
  logic        in_debug;
  logic        rflag;
  logic [3:0]  ibus_watch;
  logic        cmp_e;
  logic        cmp_f;
  logic        cmp_g;
  logic        cmp_h;
  logic        dp_load;
  logic [1:0]  dp_cfg;
  logic        fire;
  logic [4:0]  fire_sel;
  logic [18:0] evt;
  logic        debug_entry_req;
  logic [1:0]  ls_watch;
  logic        seen;
  logic        ls_bp;
  logic        exp_w;
  logic [15:0] p;
  int          fails;
  int          n_compared;

  dbgev_core_model dbgev_core_model_i (.fire(fire), .fire_sel(fire_sel), .evt(evt));

  dbgev_top dbgev_top_i (
    .clock(clock), .arst_n(arst_n), .spr_addr(spr_addr), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .debug_enabled(debug_enabled),
    .in_debug(in_debug), .recoverable_state_flag(rflag), .ibus_watch(ibus_watch),
    .ibus_brk_raw(evt[18]), .cmp_match_e(cmp_e), .cmp_match_f(cmp_f), .cmp_match_g(cmp_g),
    .cmp_match_h(cmp_h), .devport_trap_load(dp_load), .devport_trap_cfg(dp_cfg),
    .evt_checkstop(evt[0]), .evt_machine_check(evt[1]), .evt_data_storage(evt[2]),
    .evt_instr_storage(evt[3]), .evt_ext_interrupt(evt[4]), .evt_alignment(evt[5]),
    .evt_program(evt[6]), .evt_fp_unavailable(evt[7]), .evt_decrementer(evt[8]),
    .evt_system_call(evt[9]), .single_step(evt[10]), .branch_trace(evt[11]),
    .evt_fp_assist(evt[12]), .evt_sw_emulation(evt[13]), .ext_brk_module(evt[14]),
    .ext_brk_devport(evt[15]), .devport_nmi(evt[16]), .debug_from_reset(evt[17]),
    .debug_entry_req(debug_entry_req), .ls_watch(ls_watch), .ls_breakpoint(ls_bp),
    .instr_breakpoint(seen)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    spr_addr = a;
    spr_wdata = d;
    spr_wr = 1'b1;
    tick();
    spr_wr = 1'b0;
  endtask

  // read data is registered, taken one edge after the strobe; an idle edge keeps reads apart
  task automatic rdr(input logic [9:0] a);
    spr_addr = a;
    spr_rd = 1'b1;
    tick();
    spr_rd = 1'b0;
    rd = spr_rdata;
    tick();
  endtask

  task automatic fire_evt(input int i);
    fire_sel = 5'(i);
    fire = 1'b1;
    tick();
    fire = 1'b0;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    arst_n = 1'b1;
  endtask

  task automatic reset_values();
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h0);
    rdr(SPR_ENTRY_ENABLE);
    check(rd, EXP_EN);
    rdr(SPR_LS_WATCH_CTL2);
    check(rd, 32'h0);
    rdr(SPR_COUNTER_A);
    check(rd & 32'h0000_FFFF, 32'h0);
    rdr(SPR_COUNTER_B);
    check(rd & 32'h0000_FFFF, 32'h0);
    rdr(10'h0A0);
    check(rd, 32'h0);
  endtask

  task automatic close_out();
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic la_hit(input logic [1:0] la, input logic e, input logic f);
    case (la)
      2'h0: return e;
      2'h1: return f;
      2'h2: return e & f;
      default: return e | f;
    endcase
  endfunction

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    {spr_addr, spr_wr, spr_rd, spr_wdata, fire, fire_sel, dp_load, dp_cfg} = '0;
    {debug_enabled, in_debug, rflag, ibus_watch, cmp_e, cmp_f, cmp_g, cmp_h} = '0;
    void'($urandom(17592));
    do_reset();
    reset_values();
    debug_enabled = 1'b1;
    in_debug = 1'b1;
    rflag = 1'b1;
    for (int i = 0; i < 19; i++) begin
      fire_evt(i);
      if (i < 18) check(32'(debug_entry_req), 32'(EXP_EN[SRC_BIT[i]]));
      check(32'(seen), 32'(i == 18));
      tick();
      tick();
      rdr(SPR_DEBUG_CAUSE);
      check(rd, 32'h1 << SRC_BIT[i]);
      rdr(SPR_DEBUG_CAUSE);
      check(rd, 32'h0);
    end
    // clearing read is held off while enabled and outside debug mode
    in_debug = 1'b0;
    fire_evt(0);
    wr(SPR_DEBUG_CAUSE, 32'hFFFF_FFFF);
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h2000_0000);
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h2000_0000);
    debug_enabled = 1'b0;
    fire_evt(10);
    check(32'(debug_entry_req), 32'h0);
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h2002_0000);
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h0);
    in_debug = 1'b1;
    repeat (4) begin
      en = $urandom;
      wr(SPR_ENTRY_ENABLE, en);
      rdr(SPR_ENTRY_ENABLE);
      check(rd, en & CAUSES);
      repeat (6) begin
        fire_sel = 5'($urandom_range(17, 0));
        debug_enabled = 1'($urandom_range(1, 0));
        fire = 1'b1;
        tick();
        fire = 1'b0;
        check(32'(debug_entry_req), 32'(debug_enabled & en[SRC_BIT[fire_sel]]));
        debug_enabled = 1'b1;
        rdr(SPR_DEBUG_CAUSE);
      end
    end
    // watchpoint one: first ibus watchpoint cared, load-address select swept
    // c[5] cares about load data on G; H runs opposite to catch a wrong pick
    for (int c = 0; c < 64; c++) begin
      wr(SPR_LS_WATCH_CTL2, 32'h9200_0000 | (32'(c[1:0]) << 26) | (32'(c[5]) << 22));
      ibus_watch[0] = c[4];
      cmp_e = c[2];
      cmp_f = c[3];
      cmp_g = c[1];
      cmp_h = ~c[1];
      tick();
      {ibus_watch, cmp_e, cmp_f, cmp_g, cmp_h} = '0;
      exp_w = c[4] & la_hit(c[1:0], c[2], c[3]) & (~c[5] | c[1]);
      check(32'(ls_watch), 32'(exp_w));
    end
    for (int c = 0; c < 3; c++) begin
      rflag = c[0];
      wr(SPR_LS_WATCH_CTL2, 32'h9200_0002 | (32'(c[1]) << 11));
      ibus_watch[0] = 1'b1;
      cmp_e = 1'b1;
      tick();
      {ibus_watch, cmp_e} = '0;
      check(32'(ls_bp), 32'(c != 0));
      repeat (4) tick();
      rdr(SPR_DEBUG_CAUSE);
      check(32'(rd[3]), 32'(c != 0));
      rdr(SPR_DEBUG_CAUSE);
    end
    rflag = 1'b1;
    wr(SPR_LS_WATCH_CTL2, 32'hFFFF_FFFF);
    rdr(SPR_LS_WATCH_CTL2);
    check(rd & 32'h0000_0FFF, 32'h0000_0803);
    dp_load = 1'b1;
    dp_cfg = 2'h3;
    tick();
    dp_load = 1'b0;
    wr(SPR_LS_WATCH_CTL2, 32'h0);
    rdr(SPR_LS_WATCH_CTL2);
    check(rd & 32'h0000_0FFF, 32'h0000_000C);
    dp_load = 1'b1;
    dp_cfg = 2'h0;
    tick();
    dp_load = 1'b0;
    // k[0] picks the counter, k[1] turns its ibus source on
    for (int k = 0; k < 4; k++) begin
      wr(10'(SPR_COUNTER_A + k[0]), {16'h0002, 14'h0, 1'b0, k[1]});
      rdr(10'(SPR_COUNTER_A + k[0]));
      check(rd, {16'h0002, 14'h0, 1'b0, k[1]});
      rdr(SPR_DEBUG_CAUSE);
      repeat (2) begin
        ibus_watch[k[0]] = 1'b1;
        tick();
        ibus_watch = '0;
        tick();
      end
      repeat (5) tick();
      rdr(SPR_DEBUG_CAUSE);
      check(rd, 32'(k[1]) << 2);
    end
    p = 16'($urandom);
    wr(SPR_COUNTER_B, {p, 14'h3FFF, 2'h2});
    rdr(SPR_COUNTER_B);
    check(rd, {p, 14'h0, 2'h2});
    // counter B on the second load/store watchpoint: the trap waits for expiry
    wr(SPR_COUNTER_B, {16'h0001, 14'h0, 2'h2});
    tick();
    wr(SPR_LS_WATCH_CTL2, 32'h0020_0000);
    tick();
    wr(SPR_LS_WATCH_CTL2, 32'h0);
    rdr(SPR_DEBUG_CAUSE);
    check(rd, 32'h0000_0008);
    do_reset();
    reset_values();
    close_out();
  end
endmodule // debug_event_entry_logic_tb_top
